//--- shared/fpbs_pkg.sv
// shared constants and types of the front panel button sequencer
package fpbs_pkg;
    // clock and base time units
    localparam int CLK_NS      = 8;          // ref_clk period, ns
    localparam int MS_NS       = 1000000;    // one millisecond in ns
    localparam int TICK_CYC    = MS_NS / CLK_NS; // cycles per 1 ms tick
    localparam int MS_PER_S    = 1000;
    // sequence times, in their own units
    localparam int HOLD1_S     = 5;          // first hold stage, s
    localparam int HOLD2_S     = 10;         // second hold stage, s
    localparam int CONF_S      = 3;          // confirm window, s
    localparam int LOCK_MS     = 100;        // pairing window of both buttons
    localparam int DEB_MS      = 20;         // button debounce
    localparam int DARK_MS     = 1000;       // dark pause after a confirmed sequence
    // derived counts in 1 ms ticks
    localparam int MSW         = 14;
    localparam logic [MSW-1:0] HOLD1_T = MSW'(HOLD1_S * MS_PER_S);
    localparam logic [MSW-1:0] HOLD2_T = MSW'(HOLD2_S * MS_PER_S);
    localparam logic [MSW-1:0] CONF_T  = MSW'(CONF_S * MS_PER_S);
    localparam logic [MSW-1:0] DARK_T  = MSW'(DARK_MS);
    localparam logic [6:0]     LOCK_T  = 7'(LOCK_MS);
    // blink half periods in ms and blink counts
    localparam logic [9:0] FP_HALF_SLOW = 10'd250;
    localparam logic [9:0] FP_HALF_FAST = 10'd100;
    localparam logic [9:0] FP_HALF_ACK  = 10'd150;
    localparam logic [9:0] AL_HALF_SLOW = 10'd500;
    localparam logic [9:0] AL_HALF_FAST = 10'd100; // 200 ms period
    localparam logic [2:0] LOCK_BLINKS  = 3'd4;
    localparam logic [2:0] LOCKED_BLINKS = 3'd3;
    localparam logic [1:0] CONF_PRESSES = 2'd3;
    // register map, byte addresses
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_STAT    = 8'h04;
    localparam logic [7:0] REG_INT_ST  = 8'h08;
    localparam logic [7:0] REG_INT_CLR = 8'h0c;
    localparam logic [7:0] REG_INT_EN  = 8'h10;
    // control bits
    localparam int CTRL_DHCP   = 0;
    localparam int CTRL_LOCK   = 1;
    localparam logic DHCP_RST  = 1'b0;       // factory: static address
    // interrupt bits
    localparam int IW          = 5;
    localparam int IRQ_IDENT   = 0;
    localparam int IRQ_LOCK    = 1;
    localparam int IRQ_DHCP    = 2;
    localparam int IRQ_FACT    = 3;
    localparam int IRQ_REFUSE  = 4;
    // sequencer states, gray along the hold path
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_HOLD   = 3'b001,
        ST_HOLD5  = 3'b011,
        ST_HOLD10 = 3'b010,
        ST_CONF   = 3'b110,
        ST_DARK   = 3'b111,
        ST_BOOT   = 3'b100
    } fpbs_state_t;
    // register bus request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } fpbs_bus_req_t;
endpackage

//--- rtl/fpbs_debounce.sv
// button synchroniser and debouncer
`timescale 1ns/100ps
`default_nettype none
module fpbs_debounce #(
    parameter int DEB = 20
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // 1 ms tick
    input  wire logic tick,
    // raw pin and results
    input  wire logic pin,
    output logic      sync_o,
    output logic      level
);
    import fpbs_pkg::*;

    typedef struct packed {
        logic       s1;   // first sync stage, read only by s2
        logic       s2;   // second sync stage
        logic       lvl;  // debounced level
        logic [5:0] cnt;  // stable time in ms
    } fpbs_deb_t;

    fpbs_deb_t s_r, s_nxt;

    // level only moves after DEB ms of stable input
    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = pin;
        s_nxt.s2 = s_r.s1;
        if (s_r.s2 == s_r.lvl) begin
            s_nxt.cnt = 6'h00;
        end else if (tick) begin
            if (s_r.cnt == 6'(DEB - 1)) begin
                s_nxt.lvl = s_r.s2;
                s_nxt.cnt = 6'h00;
            end else begin
                s_nxt.cnt = s_r.cnt + 6'h01;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_o = s_r.s2;
    assign level  = s_r.lvl;
endmodule
`default_nettype wire

//--- rtl/fpbs_blinker.sv
// led blink pattern generator: n blinks or continuous
`timescale 1ns/100ps
`default_nettype none
module fpbs_blinker (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // 1 ms tick
    input  wire logic       tick,
    // control
    input  wire logic       start,
    input  wire logic       stop,
    input  wire logic [9:0] half_ms,
    input  wire logic [2:0] count,
    // pattern
    output logic            led,
    output logic            busy
);
    import fpbs_pkg::*;

    typedef struct packed {
        logic [9:0] half; // latched half period
        logic [9:0] cnt;  // ms in this half
        logic [2:0] left; // blinks to go
        logic       inf;  // count of zero runs forever
        logic       led;
        logic       run;
    } fpbs_blink_t;

    fpbs_blink_t s_r, s_nxt;

    // stop beats start so a dark request always wins
    always_comb begin
        s_nxt = s_r;
        if (stop) begin
            s_nxt.run = 1'b0;
            s_nxt.led = 1'b0;
        end else if (start) begin
            s_nxt.half = half_ms;
            s_nxt.left = count;
            s_nxt.inf  = (count == 3'd0);
            s_nxt.cnt  = 10'h000;
            s_nxt.led  = 1'b1;
            s_nxt.run  = 1'b1;
        end else if (s_r.run && tick) begin
            if (s_r.cnt + 10'h001 >= s_r.half) begin
                s_nxt.cnt = 10'h000;
                s_nxt.led = ~s_r.led;
                // an off edge closes one blink
                if (s_r.led && !s_r.inf) begin
                    s_nxt.left = s_r.left - 3'd1;
                    if (s_r.left == 3'd1) begin
                        s_nxt.run = 1'b0;
                    end
                end
            end else begin
                s_nxt.cnt = s_r.cnt + 10'h001;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign led  = s_r.led;
    assign busy = s_r.run;
endmodule
`default_nettype wire

//--- rtl/fpbs_top.sv
// front panel button sequencer: hold stages, lock, boot strap, leds, registers
`timescale 1ns/100ps
`default_nettype none
module fpbs_top #(
    parameter int TICK_CYC_P = fpbs_pkg::TICK_CYC, // cycles per 1 ms tick
    parameter int DEB_P      = fpbs_pkg::DEB_MS
) (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // button pins, high while pressed
    input  wire logic                    identify_button,
    input  wire logic                    audio_sel_button,
    input  wire logic                    reset_button,
    // register bus
    input  wire fpbs_pkg::fpbs_bus_req_t bus_req,
    output logic [31:0]                  bus_rdata,
    // leds
    output logic                         fp_led_override,
    output logic                         fp_led_on,
    output logic                         alive_indicator,
    // settings and system requests
    output logic                         dhcp_en,
    output logic                         lock_on,
    output logic                         boot_mode,
    output logic                         ident_evt,
    output logic                         audio_evt,
    output logic                         restore_req,
    output logic                         reboot_req,
    // interrupt
    output logic                         irq
);
    import fpbs_pkg::*;

    // whole state of the sequencer
    typedef struct packed {
        logic [16:0]    div;      // tick divider
        logic           tick;     // 1 ms enable pulse
        fpbs_state_t    st;
        logic [MSW-1:0] ms;       // stage timer
        logic [1:0]     presses;  // confirm presses seen
        logic           fact;     // sequence is the factory one
        logic           started;  // strap sampled
        logic           boot;
        logic           dhcp;
        logic           lock;
        logic           i_prev;
        logic           a_prev;
        logic           r_prev;
        logic [6:0]     i_age;    // ms since identify press
        logic [6:0]     a_age;    // ms since audio press
        logic           fp_ovr;
        logic           fp_start;
        logic           fp_stop;
        logic [9:0]     fp_half;
        logic [2:0]     fp_cnt;
        logic           al_start;
        logic [9:0]     al_half;
        logic [IW-1:0]  ist;      // sticky interrupt status
        logic [IW-1:0]  ien;      // interrupt enables
        logic           irq;
        logic [31:0]    rdata;
        logic           ident_evt;
        logic           audio_evt;
        logic           restore;
        logic           reboot;
    } fpbs_top_t;

    fpbs_top_t s_r, s_nxt;

    logic i_lvl;   // debounced identify
    logic i_sync;  // synchronised identify, for the strap
    logic a_lvl;   // debounced audio select
    logic r_lvl;   // debounced reset button
    logic fp_led;  // front blinker pattern
    logic fp_busy; // front blinker running
    logic al_led;  // alive blinker pattern

    // the three buttons share one debouncer design
    fpbs_debounce #(.DEB(DEB_P)) u_deb_ident (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tick    (s_r.tick),
        .pin     (identify_button),
        .sync_o  (i_sync),
        .level   (i_lvl)
    );

    fpbs_debounce #(.DEB(DEB_P)) u_deb_audio (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tick    (s_r.tick),
        .pin     (audio_sel_button),
        .sync_o  (),
        .level   (a_lvl)
    );

    fpbs_debounce #(.DEB(DEB_P)) u_deb_reset (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tick    (s_r.tick),
        .pin     (reset_button),
        .sync_o  (),
        .level   (r_lvl)
    );

    // front panel pattern
    fpbs_blinker u_blink_fp (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tick    (s_r.tick),
        .start   (s_r.fp_start),
        .stop    (s_r.fp_stop),
        .half_ms (s_r.fp_half),
        .count   (s_r.fp_cnt),
        .led     (fp_led),
        .busy    (fp_busy)
    );

    // alive indicator pattern, always continuous
    fpbs_blinker u_blink_alive (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tick    (s_r.tick),
        .start   (s_r.al_start),
        .stop    (1'b0),
        .half_ms (s_r.al_half),
        .count   (3'd0),
        .led     (al_led),
        .busy    ()
    );

    // next state
    always_comb begin
        logic i_rise;
        logic a_rise;
        logic r_rise;
        logic pair;
        i_rise = 1'b0;
        a_rise = 1'b0;
        r_rise = 1'b0;
        pair   = 1'b0;
        s_nxt  = s_r;
        // pulses default low
        s_nxt.tick      = 1'b0;
        s_nxt.fp_start  = 1'b0;
        s_nxt.fp_stop   = 1'b0;
        s_nxt.al_start  = 1'b0;
        s_nxt.ident_evt = 1'b0;
        s_nxt.audio_evt = 1'b0;
        s_nxt.restore   = 1'b0;
        s_nxt.reboot    = 1'b0;
        s_nxt.rdata     = 32'h0000_0000;

        // 1 ms enable from the divider
        if (s_r.div == 17'(TICK_CYC_P - 1)) begin
            s_nxt.div  = 17'h00000;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + 17'h00001;
        end

        // edges of the debounced buttons
        i_rise = i_lvl & ~s_r.i_prev;
        a_rise = a_lvl & ~s_r.a_prev;
        r_rise = r_lvl & ~s_r.r_prev;
        s_nxt.i_prev = i_lvl;
        s_nxt.a_prev = a_lvl;
        s_nxt.r_prev = r_lvl;

        // press ages saturate just past the pairing window
        if (s_r.tick && s_r.i_age <= LOCK_T) begin
            s_nxt.i_age = s_r.i_age + 7'h01;
        end
        if (s_r.tick && s_r.a_age <= LOCK_T) begin
            s_nxt.a_age = s_r.a_age + 7'h01;
        end
        if (i_rise) begin
            s_nxt.i_age = 7'h00;
        end
        if (a_rise) begin
            s_nxt.a_age = 7'h00;
        end
        pair = (i_rise && s_nxt.a_age <= LOCK_T) || (a_rise && s_nxt.i_age <= LOCK_T);

        // software writes first, so hardware updates below win
        if (bus_req.wr) begin
            case (bus_req.addr)
                REG_CTRL: begin
                    s_nxt.dhcp = bus_req.wdata[CTRL_DHCP];
                    s_nxt.lock = bus_req.wdata[CTRL_LOCK];
                end
                REG_INT_CLR: s_nxt.ist = s_r.ist & ~bus_req.wdata[IW-1:0];
                REG_INT_EN:  s_nxt.ien = bus_req.wdata[IW-1:0];
                default: ;
            endcase
        end

        // read data stand for exactly one cycle
        if (bus_req.rd) begin
            case (bus_req.addr)
                REG_CTRL:   s_nxt.rdata = {30'h0, s_r.lock, s_r.dhcp};
                REG_STAT:   s_nxt.rdata = {27'h0, s_r.fp_ovr, s_r.boot, s_r.st};
                REG_INT_ST: s_nxt.rdata = {27'h0, s_r.ist};
                REG_INT_EN: s_nxt.rdata = {27'h0, s_r.ien};
                default:    s_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // reset button asks the system for a plain reboot
        if (r_rise) begin
            s_nxt.reboot = 1'b1;
        end

        if (!s_r.started) begin
            // strap: wait a tick so the synchroniser has settled
            if (s_r.tick) begin
                s_nxt.started  = 1'b1;
                s_nxt.boot     = i_sync;
                s_nxt.al_start = 1'b1;
                s_nxt.al_half  = i_sync ? AL_HALF_FAST : AL_HALF_SLOW;
                if (i_sync) begin
                    s_nxt.st      = ST_BOOT;
                    s_nxt.fp_ovr  = 1'b1;
                    s_nxt.fp_stop = 1'b1;
                end
            end
        end else if (!s_r.boot) begin
            // release the leds once an ack pattern ends, locked or not
            if (s_r.st == ST_IDLE && !fp_busy && !s_r.fp_start) begin
                s_nxt.fp_ovr = 1'b0;
            end
            // sequencer runs only while unlocked
            if (!s_r.lock) begin
                if (i_rise) begin
                    s_nxt.ident_evt       = 1'b1;
                    s_nxt.ist[IRQ_IDENT] = 1'b1;
                end
                if (a_rise) begin
                    s_nxt.audio_evt = 1'b1;
                end
                case (s_r.st)
                    ST_IDLE: begin
                        if (i_rise) begin
                            s_nxt.st = ST_HOLD;
                            s_nxt.ms = '0;
                        end
                    end
                    ST_HOLD: begin
                        if (!i_lvl) begin
                            s_nxt.st = ST_IDLE;
                        end else if (s_r.tick) begin
                            s_nxt.ms = s_r.ms + MSW'(1);
                            if (s_r.ms + MSW'(1) == HOLD1_T) begin
                                s_nxt.st       = ST_HOLD5;
                                s_nxt.fp_ovr   = 1'b1;
                                s_nxt.fp_start = 1'b1;
                                s_nxt.fp_half  = FP_HALF_SLOW;
                                s_nxt.fp_cnt   = 3'd0;
                            end
                        end
                    end
                    ST_HOLD5: begin
                        if (!i_lvl) begin
                            s_nxt.st      = ST_CONF;
                            s_nxt.fact    = 1'b0;
                            s_nxt.ms      = '0;
                            s_nxt.presses = 2'd0;
                        end else if (s_r.tick) begin
                            s_nxt.ms = s_r.ms + MSW'(1);
                            if (s_r.ms + MSW'(1) == HOLD2_T) begin
                                s_nxt.st       = ST_HOLD10;
                                s_nxt.fp_start = 1'b1;
                                s_nxt.fp_half  = FP_HALF_FAST;
                                s_nxt.fp_cnt   = 3'd0;
                            end
                        end
                    end
                    ST_HOLD10: begin
                        // holding longer changes nothing
                        if (!i_lvl) begin
                            s_nxt.st      = ST_CONF;
                            s_nxt.fact    = 1'b1;
                            s_nxt.ms      = '0;
                            s_nxt.presses = 2'd0;
                        end
                    end
                    ST_CONF: begin
                        if (i_rise) begin
                            s_nxt.presses = s_r.presses + 2'd1;
                            if (s_r.presses + 2'd1 == CONF_PRESSES) begin
                                s_nxt.st      = ST_DARK;
                                s_nxt.ms      = '0;
                                s_nxt.fp_stop = 1'b1;
                                if (s_r.fact) begin
                                    s_nxt.restore        = 1'b1;
                                    s_nxt.dhcp           = DHCP_RST;
                                    s_nxt.ist[IRQ_FACT] = 1'b1;
                                end else begin
                                    s_nxt.dhcp           = 1'b1;
                                    s_nxt.ist[IRQ_DHCP] = 1'b1;
                                end
                            end
                        end else if (s_r.tick) begin
                            s_nxt.ms = s_r.ms + MSW'(1);
                            // window timed out: give up, settings untouched
                            if (s_r.ms + MSW'(1) == CONF_T) begin
                                s_nxt.st      = ST_IDLE;
                                s_nxt.fp_stop = 1'b1;
                                s_nxt.fp_ovr  = 1'b0;
                            end
                        end
                    end
                    ST_DARK: begin
                        // leds held dark, then reboot after a restore
                        if (s_r.tick) begin
                            s_nxt.ms = s_r.ms + MSW'(1);
                            if (s_r.ms + MSW'(1) == DARK_T) begin
                                s_nxt.st     = ST_IDLE;
                                s_nxt.fp_ovr = 1'b0;
                                s_nxt.reboot = s_r.fact;
                            end
                        end
                    end
                    default: s_nxt.st = ST_IDLE;
                endcase
            end else if (i_rise || a_rise) begin
                // locked: press refused, shown by three blinks
                s_nxt.fp_ovr           = 1'b1;
                s_nxt.fp_start         = 1'b1;
                s_nxt.fp_half          = FP_HALF_ACK;
                s_nxt.fp_cnt           = LOCKED_BLINKS;
                s_nxt.ist[IRQ_REFUSE] = 1'b1;
            end
            // a pair overrides the next state and the blinks of the sequence and the refusal, but a blinker stop set by the sequence in the same cycle still wins
            if (pair) begin
                s_nxt.lock           = ~s_r.lock;
                s_nxt.st             = ST_IDLE;
                s_nxt.fp_ovr         = 1'b1;
                s_nxt.fp_start       = 1'b1;
                s_nxt.fp_half        = FP_HALF_ACK;
                s_nxt.fp_cnt         = LOCK_BLINKS;
                s_nxt.ist[IRQ_LOCK] = 1'b1;
            end
        end

        // level interrupt from enabled sticky bits
        s_nxt.irq = |(s_nxt.ist & s_nxt.ien);
    end

    // state register, settings take factory values at reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_r      <= '0;
            s_r.st   <= ST_IDLE;
            s_r.dhcp <= DHCP_RST;
            s_r.i_age <= LOCK_T + 7'h01; // no press seen yet
            s_r.a_age <= LOCK_T + 7'h01;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign bus_rdata       = s_r.rdata;
    assign fp_led_override = s_r.fp_ovr;
    assign fp_led_on       = fp_led;
    assign alive_indicator = al_led;
    assign dhcp_en         = s_r.dhcp;
    assign lock_on         = s_r.lock;
    assign boot_mode       = s_r.boot;
    assign ident_evt       = s_r.ident_evt;
    assign audio_evt       = s_r.audio_evt;
    assign restore_req     = s_r.restore;
    assign reboot_req      = s_r.reboot;
    assign irq             = s_r.irq;
endmodule
`default_nettype wire

//--- sim/fpbs_op.sv
// operator model that presses the front panel buttons
`timescale 1ns/100ps
`default_nettype none
module fpbs_op (
    // clock
    input  wire logic       ref_clk,
    // pins: 0 identify, 1 audio, 2 reset
    output var  logic [2:0] btn
);
    initial btn = 3'h0; // released pins read low
    // press mask m for on clocks, then rest off clocks
    task automatic push(input logic [2:0] m, input int on, input int off);
        @(posedge ref_clk) btn <= m; // a pair lands together
        repeat (on) @(posedge ref_clk);
        btn <= 3'h0;
        repeat (off) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

//--- sim/fpbs_top_chk.sv
// port assertions of the button sequencer
`timescale 1ns/100ps
`default_nettype none
module fpbs_chk (
    // clock and reset
    input wire logic                    ref_clk,
    input wire logic                    rst_n,
    // watched ports
    input wire fpbs_pkg::fpbs_bus_req_t bus_req,
    input wire logic                    fp_led_override,
    input wire logic                    fp_led_on,
    input wire logic                    dhcp_en,
    input wire logic                    lock_on,
    input wire logic                    boot_mode,
    input wire logic                    ident_evt,
    input wire logic                    restore_req,
    input wire logic                    reboot_req
);
    import fpbs_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    evt_pulse_a: assert property (
        ident_evt |=> !ident_evt) else $error("identify event too long");
    locked_quiet_a: assert property (
        lock_on && $past(lock_on) |-> !ident_evt) else $error("event while locked");
    lock_ack_a: assert property (
        $changed(lock_on) |-> ##[0:4] fp_led_override) else $error("lock change unseen");
    boot_dark_a: assert property (
        boot_mode && $past(boot_mode) |-> fp_led_override && !fp_led_on)
        else $error("front leds lit in upgrade mode");
    boot_keep_a: assert property (
        boot_mode |=> boot_mode) else $error("upgrade mode lost");
    restore_static_a: assert property (
        restore_req |-> ##[0:1] !dhcp_en) else $error("restore left dynamic address");
    reboot_pulse_a: assert property (
        reboot_req |=> !reboot_req) else $error("reboot request too long");
    dhcp_dark_a: assert property (
        $rose(dhcp_en) && !$past(bus_req.wr) |-> fp_led_override)
        else $error("dynamic address without dark leds");
    // main scenarios reached
    cover property ($rose(lock_on));
    cover property ($rose(dhcp_en));
    cover property (restore_req);
    cover property ($rose(boot_mode));
endmodule
bind fpbs_top fpbs_chk chk (.ref_clk, .rst_n, .bus_req, .fp_led_override, .fp_led_on,
    .dhcp_en, .lock_on, .boot_mode, .ident_evt, .restore_req, .reboot_req);
`default_nettype wire

//--- sim/tb.sv
// self-checking bench of the button sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
    import fpbs_pkg::*;
    localparam int MS = 4; // clocks per 1 ms tick, short for sim
    logic          ref_clk = 1'b0;
    logic          rst_n   = 1'b0;
    fpbs_bus_req_t req     = '0;
    logic [31:0]   rdat, r;
    logic [2:0]    btn;
    logic          ovr, led, alive, dhcp, lock, boot, iev, aev, rsq, rbt, irq;
    int            n_fail, checks, n_iev, n_rbt, n_rsq, n_aev, n;
    always #4 ref_clk = ~ref_clk; // 125 MHz
    // tally of one cycle pulses
    always @(posedge ref_clk) begin
        if (iev === 1'b1) n_iev <= n_iev + 1;
        if (aev === 1'b1) n_aev <= n_aev + 1;
        if (rbt === 1'b1) n_rbt <= n_rbt + 1;
        if (rsq === 1'b1) n_rsq <= n_rsq + 1;
    end
    fpbs_op op (.ref_clk, .btn);
    fpbs_top #(.TICK_CYC_P(MS), .DEB_P(2)) uut (.ref_clk, .rst_n,
        .identify_button(btn[0]), .audio_sel_button(btn[1]), .reset_button(btn[2]),
        .bus_req(req), .bus_rdata(rdat), .fp_led_override(ovr), .fp_led_on(led),
        .alive_indicator(alive), .dhcp_en(dhcp), .lock_on(lock), .boot_mode(boot),
        .ident_evt(iev), .audio_evt(aev), .restore_req(rsq), .reboot_req(rbt), .irq);
    task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic ms(input int k);
        repeat (k * MS) @(negedge ref_clk);
    endtask
    // one bus cycle; read data lands in r
    task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
        @(posedge ref_clk) req <= '{a, d, w, !w};
        @(posedge ref_clk) req <= '0;
        #1 r = rdat;
    endtask
    task automatic do_rst;
        @(posedge ref_clk) rst_n <= 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        ms(5);
    endtask
    // length of one whole level run of s, into n
    task automatic run_len(ref logic s);
        logic v;
        repeat (2) begin
            v = s;
            for (n = 0; n < 9000 && s === v; n++) @(negedge ref_clk);
        end
    endtask
    // press m and count front blinks until the override drops
    task automatic pb(input logic [2:0] m);
        logic p;
        p = 1'b0;
        n = 0;
        fork
            op.push(m, 40, 40);
            for (int i = 0; i < 40000 && (i < 200 || ovr === 1'b1); i++) begin
                @(negedge ref_clk);
                if (led === 1'b1 && p !== 1'b1) n++;
                p = led;
            end
        join
    endtask
    task automatic t_irq;
        run_len(alive);
        cmp("alive slow", AL_HALF_SLOW * MS, n);
        cmp("static", 0, dhcp);
        bus(REG_INT_EN, 32'h1, 1'b1);
        op.push(3'h1, 40, 40);
        cmp("ident evt", 1, n_iev);
        cmp("irq", 1, irq);
        bus(REG_INT_ST, 32'h0, 1'b0);
        cmp("int st", 1, r);
        bus(REG_INT_EN, 32'h0, 1'b1);
        bus(8'h1c, 32'h0, 1'b0);
        cmp("unmapped", 0, r);
        cmp("irq masked", 0, irq);
        bus(REG_INT_CLR, 32'h1, 1'b1);
        bus(REG_INT_ST, 32'h0, 1'b0);
        cmp("int clr", 0, r);
        $display("test irq done");
    endtask
    task automatic t_lock;
        pb(3'h3);
        cmp("lock on", 1, lock);
        cmp("lock blinks", 4, n);
        pb(3'h1);
        cmp("locked blinks", 3, n);
        cmp("no evt", 2, n_iev);
        cmp("audio evt", 1, n_aev);
        pb(3'h3);
        cmp("lock off", 0, lock);
        cmp("unlock blinks", 4, n);
        $display("test lock done");
    endtask
    // hold identify for h ms plus one measured led run, then three quick presses
    task automatic seq(input int h);
        @(posedge ref_clk) op.btn <= 3'h1;
        ms(h);
        cmp("hold blink", 1, ovr);
        run_len(led);
        @(posedge ref_clk) op.btn <= 3'h0;
        ms(10);
        repeat (3) op.push(3'h1, 40, 40);
    endtask
    task automatic t_dhcp;
        seq(5050);
        ms(20);
        cmp("dhcp", 1, dhcp);
        cmp("dark", 0, led);
        ms(1100);
        op.push(3'h4, 40, 40);
        cmp("reboot", 1, n_rbt);
        cmp("kept", 1, dhcp);
        seq(10050);
        cmp("fast blink", FP_HALF_FAST * MS, n);
        for (int i = 0; i < 3000 && n_rbt < 2; i++) ms(1);
        cmp("restore", 1, n_rsq);
        cmp("reboot", 2, n_rbt);
        cmp("static", 0, dhcp);
        $display("test hold done");
    endtask
    task automatic t_boot;
        @(posedge ref_clk) op.btn <= 3'h1;
        do_rst;
        @(posedge ref_clk) op.btn <= 3'h0;
        run_len(alive);
        cmp("boot", 1, boot);
        cmp("fast alive", AL_HALF_FAST * MS, n);
        cmp("others off", 0, led);
        $display("test boot done");
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        do_rst;
        t_irq;
        t_lock;
        t_dhcp;
        t_boot;
        give_verdict;
    end
endmodule
`default_nettype wire
